// >>> design/adc_ctl_pkg.sv
// Behaviour
// [RQ1] New channel selection applies only after conversion
// [RQ2] Selection codes route single, differential, bandgap, ground
// [RQ3] Selection codes also fix differential gain
// [RQ4] Enable on; disable off and aborts conversion
// [RQ5] Single mode: each start write launches one
// [RQ6] Free running: later conversions follow each completion
// [RQ7] First conversion after enable 25, else 13
// [RQ8] Start bit reads busy; writing zero ignored
// [RQ9] Auto trigger starts on selected source rising edge
// [RQ10] Flag sets when conversion done, result updated
// [RQ11] Interrupt only when flag, enable, global enable
// [RQ12] Taking the interrupt vector clears flag
// [RQ13] Writing one clears flag, zero leaves it
// [RQ14] Prescale field divides system clock by 2..128
// [RQ15] Result pair: low byte base, high base+1
// [RQ16] Low byte read locks result until high read
// [RQ17] Software reads low byte before high byte
// [RQ18] Differential results stored in two's complement
// [RQ19] Right adjust puts result in bits 9:0
// [RQ20] Left adjust puts result in bits 15:6
// [RQ21] Adjust change reshapes visible result at once
// [RQ22] Switching to free running makes no trigger
// [RQ23] Result and flag update in same cycle
// [RQ24] Completion counted in prescaled converter clock ticks
package adc_ctl_pkg;
   // ----------------------------------------
   // Register indices (byte address is four times)
   // ----------------------------------------
   localparam logic [7:0] IDX_RES_LO = 8'h78;
   localparam logic [7:0] IDX_RES_HI = 8'h79;
   localparam logic [7:0] IDX_CTRL_A = 8'h7A;
   localparam logic [7:0] IDX_CTRL_B = 8'h7B;
   localparam logic [7:0] IDX_SEL = 8'h7C;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int A_EN = 7;
   localparam int A_START = 6;
   localparam int A_AUTO = 5;
   localparam int A_FLAG = 4;
   localparam int A_IE = 3;
   localparam int SEL_LEFT = 5;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0] RST_SEL = 8'h00;
   localparam logic [2:0] RST_PS = 3'h0;
   localparam logic [2:0] RST_TRIG = 3'h0;
   localparam logic [9:0] RST_RESULT = 10'h000;
   // ----------------------------------------
   // Conversion lengths in converter clock cycles
   // ----------------------------------------
   localparam logic [4:0] NORMAL_CYC = 5'h0D;
   localparam logic [4:0] FIRST_CYC = 5'h19;
   // ----------------------------------------
   // Selection codes, gains, trigger codes
   // ----------------------------------------
   localparam logic [4:0] SEL_DIFF_LO = 5'h08;
   localparam logic [4:0] SEL_GAIN1_LO = 5'h10;
   localparam logic [4:0] SEL_BANDGAP = 5'h1E;
   localparam logic [4:0] SEL_GROUND = 5'h1F;
   localparam logic [1:0] GAIN_1X = 2'h0;
   localparam logic [1:0] GAIN_10X = 2'h1;
   localparam logic [1:0] GAIN_200X = 2'h2;
   localparam logic [2:0] TRIG_FREE = 3'h0;
   // Conversion sequencer states
   typedef enum logic {ST_IDLE = 1'b0, ST_CONV = 1'b1} conv_state_t;
endpackage : adc_ctl_pkg

// >>> design/adc_conversion_control.sv
`timescale 1ns/100ps
module adc_conversion_control
   import adc_ctl_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Avalon-MM slave
   input wire logic [9:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Analog core
   input wire logic [9:0] core_data,
   output logic core_enable,
   output logic core_start,
   output logic [4:0] core_sel,
   output logic core_diff,
   output logic [1:0] core_gain,
   output logic core_bandgap,
   output logic core_ground,
   // Trigger sources and interrupt
   input wire logic [7:1] trig_src,
   input wire logic global_irq_en,
   input wire logic irq_ack,
   output logic irq
);
   // ----------------------------------------
   // Decoders
   // ----------------------------------------
   // Gain for a selection code
   function automatic logic [1:0] gain_of(input logic [4:0] s);
      if (s >= SEL_GAIN1_LO)
         return GAIN_1X; // [RQ3]
      else if (s[1])
         return GAIN_200X; // [RQ3]
      else
         return GAIN_10X; // [RQ3]
   endfunction : gain_of

   // Differential pair selected
   function automatic logic is_diff(input logic [4:0] s);
      return (s >= SEL_DIFF_LO) && (s < SEL_BANDGAP); // [RQ2]
   endfunction : is_diff

   // Result in the selected adjustment
   function automatic logic [15:0] fmt(input logic [9:0] r,
                                       input logic left);
      if (left)
         return {r, 6'h00}; // [RQ20]
      else
         return {6'h00, r}; // [RQ19]
   endfunction : fmt

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [7:0] idx; // Word index
   logic take_rd; // Read captured this cycle
   logic wr_ok; // Write accepted this cycle
   logic [7:0] reg_rd; // Addressed byte
   logic [15:0] shown; // Visible result pair
   logic [31:0] next_readdata;
   logic next_waitrequest;
   logic en, auto, flag, ie; // Control A bits
   logic [2:0] ps; // Prescale code
   logic [2:0] trig_sel; // Trigger source
   logic [7:0] sel; // Input select register
   conv_state_t st; // Sequencer state
   logic first_pend; // Next start initialises
   logic [4:0] cnt; // Ticks done
   logic [4:0] target; // Ticks needed
   logic [9:0] result; // Stored raw result
   logic locked; // Low byte read, high pending
   logic trig_prev; // Selected source last cycle
   logic fr_pulse; // Completion, free run relaunch
   logic [6:0] pre_cnt; // Prescale counter
   logic tick; // Converter clock pulse
   logic done; // Conversion completes now
   logic start; // Conversion launches now
   logic trig_lvl, trig_hit;
   logic [6:0] pre_lim;
   logic next_en, next_auto, next_flag, next_ie;
   logic [2:0] next_ps, next_trig_sel;
   logic [7:0] next_sel;
   conv_state_t next_st;
   logic next_first_pend, next_locked, next_trig_prev, next_fr_pulse;
   logic [4:0] next_cnt, next_target, next_core_sel;
   logic [9:0] next_result;
   logic [6:0] next_pre_cnt;
   logic next_tick, next_core_start, next_irq;

   // ----------------------------------------
   // Bus slave
   // ----------------------------------------
   // One wait cycle per access: read data is captured while waitrequest
   // is high; writes take effect on the next edge, where the access completes.
   always_comb
   begin
      idx = address[9:2];
      take_rd = read && waitrequest;
      wr_ok = write && !waitrequest;
      shown = fmt(result, sel[SEL_LEFT]); // [RQ21]
      unique case (idx)
         IDX_RES_LO: reg_rd = shown[7:0]; // [RQ15]
         IDX_RES_HI: reg_rd = shown[15:8]; // [RQ15]
         IDX_CTRL_A: reg_rd = {en, st == ST_CONV, auto, flag, ie, ps};
         IDX_CTRL_B: reg_rd = {5'h00, trig_sel};
         IDX_SEL: reg_rd = sel;
         default: reg_rd = 8'h00; // Unmapped reads zero
      endcase
      next_waitrequest = !((read || write) && waitrequest);
      next_readdata = take_rd ? {24'h000000, reg_rd} : readdata;
   end

   // Bus registers
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         waitrequest <= 1'b1;
         readdata <= 32'h00000000;
      end
      else
      begin
         waitrequest <= next_waitrequest;
         readdata <= next_readdata;
      end
   end

   // ----------------------------------------
   // Prescaler
   // ----------------------------------------
   // Codes 0 and 1 both divide by two
   always_comb
   begin
      pre_lim = (ps <= 3'h1) ? 7'h01 : 7'((8'h01 << ps) - 8'h01); // [RQ14]
      // A prescale change mid-count must not run the counter round
      if (!en || pre_cnt >= pre_lim)
         next_pre_cnt = 7'h00;
      else
         next_pre_cnt = pre_cnt + 7'h01;
      next_tick = en && (pre_cnt >= pre_lim); // [RQ14]
   end

   // Prescaler registers
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         pre_cnt <= 7'h00;
         tick <= 1'b0;
      end
      else
      begin
         pre_cnt <= next_pre_cnt;
         tick <= next_tick;
      end
   end

   // ----------------------------------------
   // Control and sequencer
   // ----------------------------------------
   always_comb
   begin
      next_en = en;
      next_auto = auto;
      next_ie = ie;
      next_ps = ps;
      next_trig_sel = trig_sel;
      next_sel = sel;
      next_locked = locked;
      // Register writes
      if (wr_ok && idx == IDX_CTRL_A)
      begin
         next_en = writedata[A_EN]; // [RQ4]
         next_auto = writedata[A_AUTO];
         next_ie = writedata[A_IE];
         next_ps = writedata[2:0];
      end
      if (wr_ok && idx == IDX_CTRL_B)
         next_trig_sel = writedata[2:0];
      if (wr_ok && idx == IDX_SEL)
         next_sel = writedata[7:0];
      // Lock taken when low byte is captured, so a completion
      // landing in the same cycle cannot split the pair
      if (take_rd && idx == IDX_RES_LO)
         next_locked = 1'b1; // [RQ16]
      else if (take_rd && idx == IDX_RES_HI)
         next_locked = 1'b0; // [RQ16]
      // Trigger: free run relaunches from completion, so switching
      // to it never sees a stale flag as an edge
      trig_lvl = (trig_sel == TRIG_FREE) ? 1'b0 : trig_src[trig_sel];
      next_trig_prev = trig_lvl;
      if (trig_sel == TRIG_FREE)
         trig_hit = fr_pulse; // [RQ6] [RQ22]
      else
         trig_hit = trig_lvl && !trig_prev; // [RQ9]
      done = (st == ST_CONV) && tick && (cnt == target - 5'h01); // [RQ24]
      next_fr_pulse = done;
      // Start: software write of one, or auto trigger; zero ignored
      start = (st == ST_IDLE) && next_en &&
              ((wr_ok && idx == IDX_CTRL_A && writedata[A_START]) ||
               (auto && trig_hit)); // [RQ5] [RQ8] [RQ9]
      next_first_pend = first_pend;
      if (next_en && !en)
         next_first_pend = 1'b1; // [RQ7]
      next_st = st;
      next_cnt = cnt;
      next_target = target;
      next_result = result;
      next_core_start = 1'b0;
      unique case (st)
         ST_IDLE:
         begin
            if (start)
            begin
               next_st = ST_CONV;
               next_cnt = 5'h00;
               next_target = next_first_pend ? FIRST_CYC
                                             : NORMAL_CYC; // [RQ7]
               next_first_pend = 1'b0;
               next_core_start = 1'b1;
            end
         end
         ST_CONV:
         begin
            if (tick)
               next_cnt = cnt + 5'h01; // [RQ24]
            if (done)
            begin
               next_st = ST_IDLE;
               if (!locked && !(take_rd && idx == IDX_RES_LO))
                  next_result = core_diff ? {~core_data[9], core_data[8:0]}
                                          : core_data; // [RQ16] [RQ18]
            end
         end
      endcase
      if (!next_en)
         next_st = ST_IDLE; // [RQ4]
      // Flag: completion wins over either clear
      next_flag = flag;
      if (wr_ok && idx == IDX_CTRL_A && writedata[A_FLAG])
         next_flag = 1'b0; // [RQ13]
      if (irq_ack)
         next_flag = 1'b0; // [RQ12]
      if (done && next_en)
         next_flag = 1'b1; // [RQ10] [RQ23]
      next_irq = next_flag && next_ie && global_irq_en; // [RQ11]
      // Selection reaches the core only between conversions
      next_core_sel = (next_st == ST_IDLE || start) ? next_sel[4:0]
                                                    : core_sel; // [RQ1]
   end

   // Control and sequencer registers
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         en <= 1'b0;
         auto <= 1'b0;
         flag <= 1'b0;
         ie <= 1'b0;
         ps <= RST_PS;
         trig_sel <= RST_TRIG;
         sel <= RST_SEL;
         st <= ST_IDLE;
         first_pend <= 1'b0;
         cnt <= 5'h00;
         target <= NORMAL_CYC;
         result <= RST_RESULT;
         locked <= 1'b0;
         trig_prev <= 1'b0;
         fr_pulse <= 1'b0;
         core_enable <= 1'b0;
         core_start <= 1'b0;
         core_sel <= 5'h00;
         core_diff <= 1'b0;
         core_gain <= GAIN_1X;
         core_bandgap <= 1'b0;
         core_ground <= 1'b0;
         irq <= 1'b0;
      end
      else
      begin
         en <= next_en;
         auto <= next_auto;
         flag <= next_flag;
         ie <= next_ie;
         ps <= next_ps;
         trig_sel <= next_trig_sel;
         sel <= next_sel;
         st <= next_st;
         first_pend <= next_first_pend;
         cnt <= next_cnt;
         target <= next_target;
         result <= next_result;
         locked <= next_locked;
         trig_prev <= next_trig_prev;
         fr_pulse <= next_fr_pulse;
         core_enable <= next_en;
         core_start <= next_core_start;
         core_sel <= next_core_sel;
         core_diff <= is_diff(next_core_sel); // [RQ2]
         core_gain <= gain_of(next_core_sel); // [RQ3]
         core_bandgap <= next_core_sel == SEL_BANDGAP; // [RQ2]
         core_ground <= next_core_sel == SEL_GROUND; // [RQ2]
         irq <= next_irq;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sel_hold_a: assert property ( // [RQ1]
      st == ST_CONV ##1 st == ST_CONV |-> $stable(core_sel))
      else $error("selection changed during conversion");
   gain_code_a: assert property ( // [RQ3]
      core_sel >= SEL_DIFF_LO && core_sel < SEL_GAIN1_LO |->
      core_gain == (core_sel[1] ? GAIN_200X : GAIN_10X))
      else $error("gain wrong for 10x/200x codes");
   abort_off_a: assert property ( // [RQ4]
      !en |-> st == ST_IDLE)
      else $error("conversion alive while disabled");
   first_len_a: assert property ( // [RQ7]
      core_start && $past(first_pend || !en) |-> target == FIRST_CYC)
      else $error("first conversion not 25 cycles");
   flag_done_a: assert property ( // [RQ10]
      done && next_en |=> flag)
      else $error("flag not set at completion");
   irq_gate_a: assert property ( // [RQ11]
      irq |-> $past(global_irq_en) && ie && flag)
      else $error("interrupt without its enables");
   ack_clear_a: assert property ( // [RQ12]
      irq_ack && !done |=> !flag)
      else $error("vector did not clear flag");
   lock_hold_a: assert property ( // [RQ16]
      locked && !(take_rd && idx == IDX_RES_HI) |=> $stable(result))
      else $error("locked result changed");
   free_run_a: assert property ( // [RQ6]
      done && auto && trig_sel == TRIG_FREE |=> trig_hit)
      else $error("free run did not relaunch");

   first_cov: cover property (core_start && target == FIRST_CYC);
   lock_cov: cover property (locked && done);
   free_cov: cover property (fr_pulse && auto ##1 core_start);
   irq_cov: cover property (irq ##1 irq_ack);
endmodule : adc_conversion_control

// >>> verification/analog_core_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Behavioural analog core
// ----------------------------------------
module analog_core_model
(
   // Clock
   input wire logic mclk,
   // Control from the converter logic
   input wire logic core_enable,
   input wire logic core_start,
   input wire logic [9:0] code_in,
   // Sample back to the converter
   output logic [9:0] core_data
);
   // Sample held for the running conversion
   logic [9:0] held = 10'h155;
   // Latch at launch; a powered-down core shows a toggling pattern,
   // so a result taken from a dead core can never look plausible
   always @(posedge mclk)
   begin
      if (core_start)
      begin
         held <= code_in;
      end
      else if (!core_enable)
      begin
         held <= ~held;
      end
   end
   assign core_data = held;
endmodule : analog_core_model

// >>> verification/test_adc_conversion_control.sv
`timescale 1ns/100ps
module test_adc_conversion_control;
   import adc_ctl_pkg::*;
   // ----------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [9:0] address = 10'h000;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h00000000;
   logic [7:1] trig_src = 7'h00;
   logic global_irq_en = 1'b0;
   logic irq_ack = 1'b0;
   logic [9:0] code_next = 10'h000;
   logic [31:0] readdata;
   logic waitrequest, core_enable, core_start, core_diff;
   logic core_bandgap, core_ground, irq;
   logic [9:0] core_data;
   logic [4:0] core_sel;
   logic [1:0] core_gain;
   // Bench bookkeeping; launch counters use NBA so readers never race
   int err_total = 0;
   int num_checks = 0;
   int cycles = 0;
   int starts = 0;
   int since = 0;
   int n0, p, c, dv, seed;
   logic [7:0] rd, lo, s;
   logic [9:0] ex;
   // ----------------------------------------
   // Design and partner
   // ----------------------------------------
   adc_conversion_control dut_u (.mclk(mclk), .rst(rst),
      .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .core_data(core_data),
      .core_enable(core_enable), .core_start(core_start),
      .core_sel(core_sel), .core_diff(core_diff), .core_gain(core_gain),
      .core_bandgap(core_bandgap), .core_ground(core_ground),
      .trig_src(trig_src), .global_irq_en(global_irq_en),
      .irq_ack(irq_ack), .irq(irq));
   analog_core_model core_u (.mclk(mclk), .core_enable(core_enable),
      .core_start(core_start), .code_in(code_next),
      .core_data(core_data));
   // ----------------------------------------
   // Clock, launch counting and timeout
   // ----------------------------------------
   always #25 mclk = ~mclk;
   always @(posedge mclk)
   begin
      cycles <= cycles + 1;
      since <= core_start ? 0 : since + 1;
      starts <= starts + (core_start ? 1 : 0);
      if (cycles == 20000)
      begin
         err_total++;
         report_and_stop();
      end
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   // One Avalon access, held until waitrequest is seen low
   task bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
      address <= {idx, 2'b00};
      writedata <= {24'h000000, d};
      write <= wr;
      read <= ~wr;
      @(posedge mclk);
      while (waitrequest !== 1'b0)
      begin
         @(posedge mclk);
      end
      rd = readdata[7:0];
      write <= 1'b0;
      read <= 1'b0;
      // Gap edge so no signal is driven twice in one step
      @(posedge mclk);
   endtask : bus
   task chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task chk_rng(input int got, input int lo_b, input int hi_b);
      num_checks++;
      if (got < lo_b || got > hi_b)
      begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, lo_b);
      end
   endtask : chk_rng
   // Wait for the interrupt line, bounded by the slowest conversion
   task wait_irq;
      int k;
      k = 0;
      @(posedge mclk);
      while (irq !== 1'b1 && k < 4000)
      begin
         @(posedge mclk);
         k++;
      end
      // A conversion that never completes must not pass silently
      chk(16'(irq), 16'h0001);
   endtask : wait_irq
   // Processor takes the vector
   task ack;
      irq_ack <= 1'b1;
      @(posedge mclk);
      irq_ack <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask : ack
   task report_and_stop;
      if (err_total == 0 && num_checks > 0)
      begin
         $display("DONE - PASS");
      end
      else
      begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : report_and_stop
   // Expected gain of a differential code
   function automatic logic [1:0] exp_gain(input logic [4:0] k);
      return k[4] ? GAIN_1X : (k[1] ? GAIN_200X : GAIN_10X);
   endfunction : exp_gain
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      seed = $urandom(37124);
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      // Reset values, unmapped index last
      for (c = 0; c < 6; c++)
      begin
         bus(1'b0, (c == 5) ? 8'h10 : IDX_RES_LO + 8'(c), 8'h00);
         chk(16'(rd), 16'h0000);
      end
      // Every selection code, applied while idle
      for (c = 0; c < 32; c++)
      begin
         bus(1'b1, IDX_SEL, 8'(c));
         @(posedge mclk);
         chk(16'(core_sel), 16'(c));
         chk(16'(core_diff), 16'(c >= 8 && c < 30));
         chk(16'({core_bandgap, core_ground}),
             16'({c == 30, c == 31}));
         if (c >= 8 && c < 30)
         begin
            chk(16'(core_gain), 16'(exp_gain(5'(c))));
         end
      end
      // First conversion after enable, then both adjustments
      bus(1'b1, IDX_SEL, 8'h00);
      global_irq_en <= 1'b1;
      code_next <= 10'h2A5;
      bus(1'b1, IDX_CTRL_A, 8'hC8);
      wait_irq();
      chk_rng(since, 48, 56);
      bus(1'b0, IDX_CTRL_A, 8'h00);
      chk(16'(rd), 16'h0098);
      bus(1'b0, IDX_RES_LO, 8'h00);
      chk(16'(rd), 16'h00A5);
      bus(1'b0, IDX_RES_HI, 8'h00);
      chk(16'(rd), 16'h0002);
      bus(1'b1, IDX_SEL, 8'h20);
      bus(1'b0, IDX_RES_LO, 8'h00);
      chk(16'(rd), 16'h0040);
      bus(1'b0, IDX_RES_HI, 8'h00);
      chk(16'(rd), 16'h00A9);
      bus(1'b1, IDX_SEL, 8'h00);
      // Interrupt gating by the global enable, then vector clear
      global_irq_en <= 1'b0;
      repeat (3) @(posedge mclk);
      chk(16'(irq), 16'h0000);
      global_irq_en <= 1'b1;
      repeat (3) @(posedge mclk);
      chk(16'(irq), 16'h0001);
      ack();
      chk(16'(irq), 16'h0000);
      // Each prescale code, random channel and sample
      for (p = 0; p < 8; p++)
      begin
         dv = (p < 2) ? 2 : (1 << p);
         s = ($urandom % 2) ? 8'($urandom % 8) : 8'(16 + $urandom % 14);
         code_next <= 10'($urandom % 1024);
         bus(1'b1, IDX_SEL, s);
         n0 = starts;
         bus(1'b1, IDX_CTRL_A, 8'hC8 | 8'(p));
         bus(1'b1, IDX_SEL, s ^ 8'h01);
         chk(16'(core_sel), 16'(s));
         bus(1'b1, IDX_CTRL_A, 8'h88 | 8'(p));
         bus(1'b0, IDX_CTRL_A, 8'h00);
         chk(16'(rd[6]), 16'h0001);
         wait_irq();
         chk_rng(since, 12 * dv, 14 * dv + 6);
         ex = (s >= 8'h08) ? {~code_next[9], code_next[8:0]} : code_next;
         bus(1'b0, IDX_RES_LO, 8'h00);
         lo = rd;
         bus(1'b0, IDX_RES_HI, 8'h00);
         chk({rd, lo}, 16'(ex));
         repeat (40) @(posedge mclk);
         chk(16'(starts - n0), 16'h0001);
         bus(1'b1, IDX_CTRL_A, 8'h88 | 8'(p));
         bus(1'b0, IDX_CTRL_A, 8'h00);
         chk(16'(rd), 16'(8'h98 | 8'(p)));
         bus(1'b1, IDX_CTRL_A, 8'h98 | 8'(p));
         bus(1'b0, IDX_CTRL_A, 8'h00);
         chk(16'(rd), 16'(8'h88 | 8'(p)));
      end
      // Low byte read holds the pair against a newer result
      bus(1'b1, IDX_SEL, 8'h00);
      code_next <= 10'h155;
      bus(1'b1, IDX_CTRL_A, 8'hC8);
      wait_irq();
      bus(1'b0, IDX_RES_LO, 8'h00);
      ack();
      code_next <= 10'h2AA;
      bus(1'b1, IDX_CTRL_A, 8'hC8);
      wait_irq();
      bus(1'b0, IDX_RES_HI, 8'h00);
      chk(16'(rd), 16'h0001);
      ack();
      // Free running, then disable in mid conversion
      bus(1'b1, IDX_CTRL_B, 8'h00);
      n0 = starts;
      bus(1'b1, IDX_CTRL_A, 8'hE0);
      repeat (100) @(posedge mclk);
      chk_rng(starts - n0, 3, 5);
      bus(1'b1, IDX_CTRL_A, 8'h10);
      chk(16'(core_enable), 16'h0000);
      bus(1'b0, IDX_CTRL_A, 8'h00);
      chk(16'(rd), 16'h0000);
      n0 = starts;
      repeat (60) @(posedge mclk);
      chk(16'(starts - n0), 16'h0000);
      // Trigger edges ignored while auto triggering is off
      bus(1'b1, IDX_CTRL_B, 8'h03);
      bus(1'b1, IDX_CTRL_A, 8'h80);
      n0 = starts;
      trig_src <= 7'h04;
      repeat (4) @(posedge mclk);
      trig_src <= 7'h00;
      repeat (4) @(posedge mclk);
      chk(16'(starts - n0), 16'h0000);
      // Auto trigger: only the chosen source launches
      bus(1'b1, IDX_CTRL_A, 8'hA0);
      n0 = starts;
      trig_src <= 7'($urandom & 32'h7B);
      repeat (4) @(posedge mclk);
      for (c = 0; c < 2; c++)
      begin
         trig_src <= 7'h00;
         repeat (4) @(posedge mclk);
         trig_src <= 7'h04;
         repeat (70) @(posedge mclk);
      end
      chk(16'(starts - n0), 16'h0002);
      // Moving to free running with the flag set makes no launch
      n0 = starts;
      bus(1'b1, IDX_CTRL_B, 8'h00);
      repeat (10) @(posedge mclk);
      chk(16'(starts - n0), 16'h0000);
      report_and_stop();
   end
endmodule : test_adc_conversion_control
